//--- include/i2cis_pkg.sv
// constants, carriers and state layout of the i2c interrupt status block
// assumes a 32-bit byte-addressed register port and a same-clock protocol engine
package i2cis_pkg;
   // register byte addresses
   localparam logic [31:0] A_STAT = 32'h5000132C;
   localparam logic [31:0] A_MASK = 32'h50001330;
   localparam logic [31:0] A_RAW = 32'h50001334;
   localparam logic [31:0] A_DATA = 32'h50001310;
   localparam logic [31:0] A_RXTL = 32'h50001338;
   localparam logic [31:0] A_TXTL = 32'h5000133C;
   localparam logic [31:0] A_CLR_ALL = 32'h50001340;
   localparam logic [31:0] A_CLR_RDREQ = 32'h50001350;
   localparam logic [31:0] A_CLR_ABRT = 32'h50001354;
   localparam logic [31:0] A_CLR_BUSY = 32'h5000135C;
   localparam logic [31:0] A_CLR_GEN = 32'h50001368;
   localparam logic [31:0] A_ON = 32'h5000136C;
   localparam logic [31:0] A_CAUSE = 32'h50001380;
   // flag positions
   localparam int B_UNDER = 0;
   localparam int B_RXOVR = 1;
   localparam int B_RXFULL = 2;
   localparam int B_TXOVR = 3;
   localparam int B_TXEMPTY = 4;
   localparam int B_RDREQ = 5;
   localparam int B_ABRT = 6;
   localparam int B_DONE = 7;
   localparam int B_BUSY = 8;
   localparam int B_STOP = 9;
   localparam int B_START = 10;
   localparam int B_GEN = 11;
   // reset values and sizes
   localparam logic [11:0] MASK_RST = 12'h8FF;
   localparam logic [5:0] FIFO_DEPTH = 6'h20;
   localparam logic [3:0] RSVD_BITS = 4'h0;
   // register port request
   typedef struct packed {
      logic rd;
      logic wr;
      logic [31:0] addr;
      logic [15:0] wdata;
   } i2cis_req_type;
   // events from the protocol engine
   typedef struct packed {
      logic gen_call;
      logic slv_nack;
      logic abort;
      logic rd_req;
      logic rx_valid;
      logic busy;
      logic tx_pop;
   } i2cis_evt_type;
   // whole state of the block
   typedef struct packed {
      logic [11:0] raw;
      logic [11:0] mask;
      logic on;
      logic ien;
      logic [7:0] txtl;
      logic [7:0] rxtl;
      logic [15:0] cause;
      logic [31:0][8:0] txmem;
      logic [4:0] txw;
      logic [4:0] txr;
      logic [5:0] txc;
      logic [31:0][7:0] rxmem;
      logic [4:0] rxw;
      logic [4:0] rxr;
      logic [5:0] rxc;
      logic [1:0] scl_s;
      logic [1:0] sda_s;
      logic scl_d;
      logic sda_d;
      logic [15:0] rdata;
      logic rvalid;
      logic [8:0] head;
      logic avail;
      logic scloe;
      logic [15:0] stat;
   } i2cis_state_type;
endpackage

//--- verilog/i2cis_status.sv
// interrupt status, masking and fifo side effects of an i2c controller
// assumes a protocol engine on ref_clk and raw scl/sda pin levels
`timescale 1ns/100ps
module i2cis_status (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire i2cis_pkg::i2cis_req_type reg_req,
   output logic [15:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic scl_pin,
   input wire logic sda_pin,
   input wire i2cis_pkg::i2cis_evt_type eng_evt,
   input wire logic [7:0] rx_byte,
   input wire logic [15:0] abort_cause,
   output logic [8:0] tx_head,
   output logic tx_avail,
   output logic internal_on_signal,
   output logic scl_o,
   output logic scl_oe,
   output logic [15:0] masked_status
);
   i2cis_pkg::i2cis_state_type s_r;
   i2cis_pkg::i2cis_state_type s_nxt;
   logic start_det;
   logic stop_det;
   logic [11:0] set_v;
   logic [11:0] clr_v;
   logic tx_push;
   logic tx_pop;
   logic rx_push;
   logic rx_pop;
   logic tx_flush;
   logic data_wr;
   logic data_rd;
   logic clr_all;

   // read strobe aimed at one address
   function automatic logic rd_hit(input i2cis_pkg::i2cis_req_type q,
                                   input logic [31:0] a);
      return q.rd && (q.addr == a);
   endfunction

   // write strobe aimed at one address
   function automatic logic wr_hit(input i2cis_pkg::i2cis_req_type q,
                                   input logic [31:0] a);
      return q.wr && (q.addr == a);
   endfunction

   // bus conditions from the second sync stage against its delayed copy
   assign start_det = s_r.scl_s[1] && s_r.scl_d && s_r.sda_d && !s_r.sda_s[1];
   assign stop_det = s_r.scl_s[1] && s_r.scl_d && !s_r.sda_d && s_r.sda_s[1];

   // strobes shared by fifos and flags
   assign data_wr = wr_hit(reg_req, i2cis_pkg::A_DATA);
   assign data_rd = rd_hit(reg_req, i2cis_pkg::A_DATA);
   assign clr_all = rd_hit(reg_req, i2cis_pkg::A_CLR_ALL);
   assign tx_flush = !s_r.on || s_r.raw[i2cis_pkg::B_ABRT];
   assign tx_push = data_wr && !tx_flush && (s_r.txc != i2cis_pkg::FIFO_DEPTH);
   assign tx_pop = eng_evt.tx_pop && (s_r.txc != 6'h00) && !tx_flush;
   // engine acks every byte; a full fifo simply drops it
   assign rx_push = eng_evt.rx_valid && s_r.on && (s_r.rxc != i2cis_pkg::FIFO_DEPTH);
   assign rx_pop = data_rd && (s_r.rxc != 6'h00) && s_r.on;

   // hardware set vector for sticky flags
   always_comb begin
      set_v = 12'h000;
      set_v[i2cis_pkg::B_GEN] = eng_evt.gen_call;
      set_v[i2cis_pkg::B_START] = start_det;
      set_v[i2cis_pkg::B_STOP] = stop_det;
      set_v[i2cis_pkg::B_BUSY] = eng_evt.busy;
      set_v[i2cis_pkg::B_DONE] = eng_evt.slv_nack;
      set_v[i2cis_pkg::B_ABRT] = eng_evt.abort;
      set_v[i2cis_pkg::B_RDREQ] = eng_evt.rd_req;
      set_v[i2cis_pkg::B_TXOVR] = data_wr && !tx_flush
                                  && (s_r.txc == i2cis_pkg::FIFO_DEPTH);
      set_v[i2cis_pkg::B_RXOVR] = eng_evt.rx_valid && s_r.on
                                  && (s_r.rxc == i2cis_pkg::FIFO_DEPTH);
      set_v[i2cis_pkg::B_UNDER] = data_rd && (s_r.rxc == 6'h00);
   end

   // clear vector; set still wins where both land in one cycle
   always_comb begin
      clr_v = {12{clr_all}};
      clr_v[i2cis_pkg::B_GEN] = clr_all || !s_r.on
                                || rd_hit(reg_req, i2cis_pkg::A_CLR_GEN);
      clr_v[i2cis_pkg::B_BUSY] = clr_all || !s_r.on
                                 || rd_hit(reg_req, i2cis_pkg::A_CLR_BUSY);
      clr_v[i2cis_pkg::B_ABRT] = clr_all
                                 || rd_hit(reg_req, i2cis_pkg::A_CLR_ABRT);
      clr_v[i2cis_pkg::B_RDREQ] = clr_all
                                  || rd_hit(reg_req, i2cis_pkg::A_CLR_RDREQ);
      clr_v[i2cis_pkg::B_TXOVR] = clr_all || !s_r.ien;
      clr_v[i2cis_pkg::B_RXOVR] = clr_all || !s_r.ien;
      clr_v[i2cis_pkg::B_UNDER] = clr_all || !s_r.ien;
      // level flags are recomputed, never cleared by software
      clr_v[i2cis_pkg::B_TXEMPTY] = 1'b0;
      clr_v[i2cis_pkg::B_RXFULL] = 1'b0;
   end

   // next state
   always_comb begin
      s_nxt = s_r;
      // pin synchronisers and edge history
      s_nxt.scl_s = {s_r.scl_s[0], scl_pin};
      s_nxt.sda_s = {s_r.sda_s[0], sda_pin};
      s_nxt.scl_d = s_r.scl_s[1];
      s_nxt.sda_d = s_r.sda_s[1];
      // software registers; status itself takes no write
      if (wr_hit(reg_req, i2cis_pkg::A_MASK)) begin
         s_nxt.mask = reg_req.wdata[11:0];
      end
      if (wr_hit(reg_req, i2cis_pkg::A_ON)) begin
         s_nxt.on = reg_req.wdata[0];
      end
      if (wr_hit(reg_req, i2cis_pkg::A_TXTL)) begin
         s_nxt.txtl = reg_req.wdata[7:0];
      end
      if (wr_hit(reg_req, i2cis_pkg::A_RXTL)) begin
         s_nxt.rxtl = reg_req.wdata[7:0];
      end
      // internal enable lingers until the engine goes idle
      s_nxt.ien = s_r.on || (s_r.ien && eng_evt.busy);
      // sticky flags
      s_nxt.raw = (s_r.raw & ~clr_v) | set_v;
      // abort cause follows its flag
      if (eng_evt.abort) begin
         s_nxt.cause = abort_cause;
      end else if (clr_v[i2cis_pkg::B_ABRT]) begin
         s_nxt.cause = 16'h0000;
      end
      // transmit fifo, flushed while disabled or aborted
      if (tx_flush) begin
         s_nxt.txw = 5'h00;
         s_nxt.txr = 5'h00;
         s_nxt.txc = 6'h00;
      end else begin
         if (tx_push) begin
            s_nxt.txmem[s_r.txw] = reg_req.wdata[8:0];
            s_nxt.txw = s_r.txw + 5'h01;
         end
         if (tx_pop) begin
            s_nxt.txr = s_r.txr + 5'h01;
         end
         s_nxt.txc = s_r.txc + {5'h00, tx_push} - {5'h00, tx_pop};
      end
      // receive fifo, flushed at once when disabled
      if (!s_r.on) begin
         s_nxt.rxw = 5'h00;
         s_nxt.rxr = 5'h00;
         s_nxt.rxc = 6'h00;
      end else begin
         if (rx_push) begin
            s_nxt.rxmem[s_r.rxw] = rx_byte;
            s_nxt.rxw = s_r.rxw + 5'h01;
         end
         if (rx_pop) begin
            s_nxt.rxr = s_r.rxr + 5'h01;
         end
         s_nxt.rxc = s_r.rxc + {5'h00, rx_push} - {5'h00, rx_pop};
      end
      // level flags from the new fill counts; transmit empty follows the engine busy input while off
      if (s_r.on) begin
         s_nxt.raw[i2cis_pkg::B_TXEMPTY] = {2'b00, s_nxt.txc} <= s_nxt.txtl;
      end else begin
         s_nxt.raw[i2cis_pkg::B_TXEMPTY] = eng_evt.busy;
      end
      s_nxt.raw[i2cis_pkg::B_RXFULL] = s_nxt.on
                                     && ({2'b00, s_nxt.rxc} >= s_nxt.rxtl);
      // read answer, one cycle after the strobe
      s_nxt.rvalid = reg_req.rd;
      s_nxt.rdata = 16'h0000;
      if (reg_req.rd) begin
         unique case (reg_req.addr)
            i2cis_pkg::A_STAT: s_nxt.rdata = s_r.stat;
            i2cis_pkg::A_MASK: s_nxt.rdata = {i2cis_pkg::RSVD_BITS, s_r.mask};
            i2cis_pkg::A_RAW: s_nxt.rdata = {i2cis_pkg::RSVD_BITS, s_r.raw};
            i2cis_pkg::A_DATA: s_nxt.rdata = rx_pop ? {8'h00, s_r.rxmem[s_r.rxr]} : 16'h0000;
            i2cis_pkg::A_RXTL: s_nxt.rdata = {8'h00, s_r.rxtl};
            i2cis_pkg::A_TXTL: s_nxt.rdata = {8'h00, s_r.txtl};
            i2cis_pkg::A_ON: s_nxt.rdata = {15'h0000, s_r.on};
            i2cis_pkg::A_CAUSE: s_nxt.rdata = s_r.cause;
            i2cis_pkg::A_CLR_ALL: s_nxt.rdata = {15'h0000, |s_r.raw};
            i2cis_pkg::A_CLR_GEN: s_nxt.rdata = {15'h0000, s_r.raw[i2cis_pkg::B_GEN]};
            i2cis_pkg::A_CLR_BUSY: s_nxt.rdata = {15'h0000, s_r.raw[i2cis_pkg::B_BUSY]};
            i2cis_pkg::A_CLR_ABRT: s_nxt.rdata = {15'h0000, s_r.raw[i2cis_pkg::B_ABRT]};
            i2cis_pkg::A_CLR_RDREQ: s_nxt.rdata = {15'h0000, s_r.raw[i2cis_pkg::B_RDREQ]};
            default: s_nxt.rdata = 16'h0000;
         endcase
      end
      // registered copies for the outputs
      s_nxt.head = s_nxt.txmem[s_nxt.txr];
      s_nxt.avail = s_nxt.txc != 6'h00;
      // stretch only while the request waits for data
      s_nxt.scloe = s_nxt.raw[i2cis_pkg::B_RDREQ] && (s_nxt.txc == 6'h00);
      s_nxt.stat = {i2cis_pkg::RSVD_BITS, s_nxt.raw & s_nxt.mask};
   end

   // one register for the whole state; pins idle high out of reset
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         s_r <= '0;
         s_r.mask <= i2cis_pkg::MASK_RST;
         s_r.scl_s <= 2'b11;
         s_r.sda_s <= 2'b11;
         s_r.scl_d <= 1'b1;
         s_r.sda_d <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   // outputs straight from the state register, except scl_o which is tied low
   assign reg_rdata = s_r.rdata;
   assign reg_rvalid = s_r.rvalid;
   assign tx_head = s_r.head;
   assign tx_avail = s_r.avail;
   assign internal_on_signal = s_r.ien;
   assign scl_o = 1'b0;
   assign scl_oe = s_r.scloe;
   assign masked_status = s_r.stat;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);

   property p_gen_set;
      eng_evt.gen_call |=> s_r.raw[i2cis_pkg::B_GEN]
                           && s_r.stat[i2cis_pkg::B_GEN] == s_r.mask[i2cis_pkg::B_GEN];
   endproperty
   a_gen_set: assert property (p_gen_set) else $error("general call flag not set");

   property p_start;
      start_det |=> s_r.raw[i2cis_pkg::B_START];
   endproperty
   a_start: assert property (p_start) else $error("start not flagged");

   property p_stop;
      (s_r.scl_s[1] && s_r.scl_d && !s_r.sda_d && s_r.sda_s[1]) |=> s_r.raw[i2cis_pkg::B_STOP];
   endproperty
   a_stop: assert property (p_stop) else $error("stop not flagged");

   property p_busy_sticky;
      s_r.raw[i2cis_pkg::B_BUSY] && s_r.on && !reg_req.rd |=> s_r.raw[i2cis_pkg::B_BUSY];
   endproperty
   a_busy_sticky: assert property (p_busy_sticky) else $error("activity flag lost");

   property p_abort_flush;
      s_r.raw[i2cis_pkg::B_ABRT] |=> s_r.txc == 6'h00 && !s_r.avail;
   endproperty
   a_abort_flush: assert property (p_abort_flush) else $error("fifo kept data in abort");

   property p_stretch;
      eng_evt.rd_req && s_r.txc == 6'h00 && !data_wr |=> scl_oe && !scl_o;
   endproperty
   a_stretch: assert property (p_stretch) else $error("scl stretch wrong");

   property p_rdreq_clr;
      rd_hit(reg_req, i2cis_pkg::A_CLR_RDREQ) && !eng_evt.rd_req |=> !s_r.raw[i2cis_pkg::B_RDREQ];
   endproperty
   a_rdreq_clr: assert property (p_rdreq_clr) else $error("read request not cleared");

   property p_txovr;
      data_wr && s_r.on && !s_r.raw[i2cis_pkg::B_ABRT] && s_r.txc == 6'h20
      |=> s_r.raw[i2cis_pkg::B_TXOVR] && s_r.txc == 6'h20;
   endproperty
   a_txovr: assert property (p_txovr) else $error("transmit overflow missed");

   property p_ovr_drop;
      !s_r.ien && !data_rd |=> !s_r.raw[i2cis_pkg::B_TXOVR] && !s_r.raw[i2cis_pkg::B_UNDER];
   endproperty
   a_ovr_drop: assert property (p_ovr_drop) else $error("error flags survive disable");

   property p_rx_off;
      !s_r.on |=> s_r.rxc == 6'h00
                  && s_r.raw[i2cis_pkg::B_RXFULL] == (s_r.on && s_r.rxtl == 8'h00);
   endproperty
   a_rx_off: assert property (p_rx_off) else $error("rx not flushed when off");

   property p_under;
      data_rd && s_r.rxc == 6'h00 |=> s_r.raw[i2cis_pkg::B_UNDER];
   endproperty
   a_under: assert property (p_under) else $error("underflow missed");

   property p_rsvd;
      s_r.stat[15:12] == 4'h0 && s_r.stat[11:0] == (s_r.raw & s_r.mask);
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("status not masked raw");

   property p_done;
      eng_evt.slv_nack |=> s_r.raw[i2cis_pkg::B_DONE];
   endproperty
   a_done: assert property (p_done) else $error("transmit done not flagged");

   property p_abort_set;
      eng_evt.abort |=> s_r.raw[i2cis_pkg::B_ABRT] && s_r.cause == $past(abort_cause);
   endproperty
   a_abort_set: assert property (p_abort_set) else $error("abort flag or cause wrong");

   property p_tx_level;
      s_r.on |=> s_r.raw[i2cis_pkg::B_TXEMPTY] == ({2'b00, s_r.txc} <= s_r.txtl);
   endproperty
   a_tx_level: assert property (p_tx_level) else $error("transmit empty level wrong");

   property p_tx_off;
      !s_r.on |=> s_r.txc == 6'h00 && s_r.raw[i2cis_pkg::B_TXEMPTY] == $past(eng_evt.busy);
   endproperty
   a_tx_off: assert property (p_tx_off) else $error("transmit side wrong when off");

   property p_rx_level;
      s_r.on && !wr_hit(reg_req, i2cis_pkg::A_ON)
      |=> s_r.raw[i2cis_pkg::B_RXFULL] == ({2'b00, s_r.rxc} >= s_r.rxtl);
   endproperty
   a_rx_level: assert property (p_rx_level) else $error("receive full level wrong");

   property p_rxovr;
      eng_evt.rx_valid && s_r.on && s_r.rxc == 6'h20 && !data_rd
      |=> s_r.raw[i2cis_pkg::B_RXOVR] && s_r.rxc == 6'h20;
   endproperty
   a_rxovr: assert property (p_rxovr) else $error("receive overflow missed");
endmodule

//--- verif/i2cis_bus_partner.sv
// model of a remote bus master that frames starts and stops on scl and sda
// assumes the bench joins scl with the block's stretch pull-down
`timescale 1ns/100ps
module i2cis_bus_partner (
   output logic scl,
   output logic sda
);
   localparam int HALF = 24; // half of the 48 ns link period
   // both lines rest at the pull-up level; the clock stands still between frames
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   // start: data falls while the clock is high, then the clock goes low
   task automatic start_cond;
      #HALF sda = 1'b0;
      #HALF scl = 1'b0;
   endtask
   // stop: data rises while the clock is high, leaving both lines released
   task automatic stop_cond;
      #HALF sda = 1'b0;
      #HALF scl = 1'b1;
      #HALF sda = 1'b1;
   endtask
endmodule

//--- verif/i2cis_status_bench.sv
// scenario bench for the i2c interrupt status block
// assumes the partner model on the pins; the protocol engine is played here
`timescale 1ns/100ps
module i2cis_status_bench;
   logic ref_clk;
   logic sys_rst;
   i2cis_pkg::i2cis_req_type req;
   i2cis_pkg::i2cis_evt_type evt;
   logic [15:0] reg_rdata;
   logic reg_rvalid;
   logic p_scl;
   logic p_sda;
   logic scl_wire;
   logic [7:0] rx_byte;
   logic [15:0] abort_cause;
   logic [8:0] tx_head;
   logic tx_avail;
   logic ien_o;
   logic scl_o;
   logic scl_oe;
   logic [15:0] mstat;
   int miscompares = 0;
   int n_compared = 0;

   // the block pulls scl low while it stretches, otherwise the partner owns it
   assign scl_wire = scl_oe ? scl_o : p_scl;

   i2cis_bus_partner p (.scl(p_scl), .sda(p_sda));

   i2cis_status dut (.ref_clk, .sys_rst, .reg_req(req), .reg_rdata, .reg_rvalid,
      .scl_pin(scl_wire), .sda_pin(p_sda), .eng_evt(evt), .rx_byte, .abort_cause,
      .tx_head, .tx_avail, .internal_on_signal(ien_o), .scl_o, .scl_oe,
      .masked_status(mstat));

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
      n_compared++;
      if (s !== e) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask

   // read and compare; the answer stands only in the cycle after the strobe
   task automatic rchk(input logic [31:0] a, input logic [15:0] e);
      req.rd = 1'b1;
      req.addr = a;
      @(negedge ref_clk);
      req.rd = 1'b0;
      chk($sformatf("reg %h", a), reg_rvalid ? reg_rdata : 16'hDEAD, e);
      @(negedge ref_clk);
   endtask

   // the extra cycle keeps back-to-back calls from re-driving the strobe at once
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      req.wr = 1'b1;
      req.addr = a;
      req.wdata = d;
      @(negedge ref_clk);
      req.wr = 1'b0;
      @(negedge ref_clk);
   endtask

   // one-cycle engine pulse: 40 gen, 20 nack, 10 abort, 08 rdreq, 04 rx, 01 pop
   task automatic ev(input logic [6:0] m);
      evt = evt | m;
      @(negedge ref_clk);
      evt = evt & ~m;
      @(negedge ref_clk);
   endtask

   task automatic t_regs;
      rchk(i2cis_pkg::A_MASK, 16'h08FF);
      rchk(i2cis_pkg::A_STAT, 16'h0000);
      wr(i2cis_pkg::A_STAT, 16'hFFFF);
      rchk(i2cis_pkg::A_STAT, 16'h0000);
      rchk(32'h50001000, 16'h0000);
   endtask

   task automatic t_levels;
      wr(i2cis_pkg::A_ON, 16'h0001);
      wr(i2cis_pkg::A_TXTL, 16'h0000);
      wr(i2cis_pkg::A_RXTL, 16'h0001);
      rchk(i2cis_pkg::A_RAW, 16'h0010);
      wr(i2cis_pkg::A_DATA, 16'h01A5);
      chk("tx_head", {7'h00, tx_head}, 16'h01A5);
      rchk(i2cis_pkg::A_RAW, 16'h0000);
      ev(7'h01);
      rx_byte = 8'h5A;
      ev(7'h04);
      rchk(i2cis_pkg::A_RAW, 16'h0014);
      rchk(i2cis_pkg::A_DATA, 16'h005A);
      rchk(i2cis_pkg::A_RAW, 16'h0010);
      rchk(i2cis_pkg::A_DATA, 16'h0000);
      rchk(i2cis_pkg::A_RAW, 16'h0011);
      rchk(i2cis_pkg::A_CLR_ALL, 16'h0001);
      rchk(i2cis_pkg::A_RAW, 16'h0010);
   endtask

   task automatic t_sticky;
      ev(7'h40);
      ev(7'h20);
      evt.busy = 1'b1;
      repeat (2) @(negedge ref_clk);
      evt.busy = 1'b0;
      rchk(i2cis_pkg::A_RAW, 16'h0990);
      rchk(i2cis_pkg::A_CLR_GEN, 16'h0001);
      rchk(i2cis_pkg::A_CLR_BUSY, 16'h0001);
      rchk(i2cis_pkg::A_RAW, 16'h0090);
      rchk(i2cis_pkg::A_CLR_ALL, 16'h0001);
      rchk(i2cis_pkg::A_RAW, 16'h0010);
   endtask

   task automatic t_bus;
      p.start_cond();
      p.stop_cond();
      @(negedge ref_clk);
      repeat (8) @(negedge ref_clk);
      rchk(i2cis_pkg::A_RAW, 16'h0610);
      rchk(i2cis_pkg::A_CLR_ALL, 16'h0001);
   endtask

   task automatic t_abort;
      wr(i2cis_pkg::A_DATA, 16'h0033);
      abort_cause = 16'h0042;
      ev(7'h10);
      chk("tx_avail", {15'h0000, tx_avail}, 16'h0000);
      rchk(i2cis_pkg::A_RAW, 16'h0050);
      rchk(i2cis_pkg::A_CAUSE, 16'h0042);
      wr(i2cis_pkg::A_DATA, 16'h0077);
      chk("tx_avail", {15'h0000, tx_avail}, 16'h0000);
      rchk(i2cis_pkg::A_CLR_ABRT, 16'h0001);
      wr(i2cis_pkg::A_DATA, 16'h0077);
      chk("tx_head", {7'h00, tx_head}, 16'h0077);
      ev(7'h01);
   endtask

   task automatic t_rdreq;
      ev(7'h08);
      chk("scl_oe", {15'h0000, scl_oe}, 16'h0001);
      chk("scl", {15'h0000, scl_wire}, 16'h0000);
      rchk(i2cis_pkg::A_RAW, 16'h0030);
      wr(i2cis_pkg::A_DATA, 16'h00AA);
      chk("scl_oe", {15'h0000, scl_oe}, 16'h0000);
      rchk(i2cis_pkg::A_CLR_RDREQ, 16'h0001);
      rchk(i2cis_pkg::A_RAW, 16'h0000);
      ev(7'h01);
   endtask

   // overflow both fifos, then disable while the engine is still active
   task automatic t_overflow;
      repeat (33) wr(i2cis_pkg::A_DATA, 16'h0001);
      rchk(i2cis_pkg::A_RAW, 16'h0008);
      rx_byte = 8'h11;
      repeat (33) ev(7'h04);
      rchk(i2cis_pkg::A_RAW, 16'h000E);
      evt.busy = 1'b1;
      wr(i2cis_pkg::A_ON, 16'h0000);
      chk("status", mstat, 16'h001A);
      chk("tx_avail", {15'h0000, tx_avail}, 16'h0000);
      chk("ien", {15'h0000, ien_o}, 16'h0001);
      evt.busy = 1'b0;
      repeat (3) @(negedge ref_clk);
      chk("status", mstat, 16'h0000);
      chk("ien", {15'h0000, ien_o}, 16'h0000);
   endtask

   task automatic t_mask;
      wr(i2cis_pkg::A_ON, 16'h0001);
      wr(i2cis_pkg::A_MASK, 16'h0000);
      chk("status", mstat, 16'h0000);
      wr(i2cis_pkg::A_MASK, 16'hFFFF);
      chk("status", mstat, 16'h0010);
      rchk(i2cis_pkg::A_STAT, 16'h0010);
   endtask

   // every input but the scl and sda pins is given a value at time zero, then changed on falling edges
   initial begin
      sys_rst = 1'b1;
      req = '0;
      evt = '0;
      rx_byte = 8'h00;
      abort_cause = 16'h0000;
      repeat (6) @(negedge ref_clk);
      sys_rst = 1'b0;
      t_regs();
      t_levels();
      t_sticky();
      t_bus();
      t_abort();
      t_rdreq();
      t_overflow();
      t_mask();
      conclude();
   end

   // the whole run is a few hundred cycles; this cuts a hang short
   initial begin
      #50000;
      miscompares++;
      conclude();
   end
endmodule
